// >>> itd_map.vh
// Constants for the isochronous transmit descriptor decoder.
// Assumes a 128-bit descriptor unit delivered by a memory fetch port.
`ifndef ITD_MAP_VH
`define ITD_MAP_VH
// Descriptor field positions (first quadlet)
`define ITD_CMD_HI        31
`define ITD_CMD_LO        28
`define ITD_STAT_BIT      27
`define ITD_KEY_HI        26
`define ITD_KEY_LO        24
`define ITD_IRQ_HI        21
`define ITD_IRQ_LO        20
`define ITD_BR_HI         19
`define ITD_BR_LO         18
`define ITD_CNT_HI        15
`define ITD_CNT_LO        0
// Command, key and interrupt codes
`define ITD_CMD_MORE      4'h0
`define ITD_CMD_LAST      4'h1
`define ITD_KEY_PLAIN     3'h0
`define ITD_KEY_IMM       3'h2
`define ITD_IRQ_ON        2'b11
// Sizes
`define ITD_UNIT_BYTES    32'h0000_0010
`define ITD_IMM_UNITS     4'h2
`define ITD_MAX_BLOCK     4'h8
// Wishbone register offsets
`define ITD_REG_CTRL      4'h0
`define ITD_REG_PTR       4'h4
`define ITD_REG_STAT      4'h8
`define ITD_REG_TIMER     4'hc
// Control bits
`define ITD_CTRL_RUN      0
`define ITD_CTRL_MISSED   1
`endif

// >>> itd_decoder.v
// Isochronous transmit descriptor decoder: fetches descriptor units,
// pushes header quadlets, requests payload, writes status back.
// Assumes a memory fetch port, a payload mover and a FIFO ready handshake.
// How it works
// - Command 0 with header key is header descriptor
// - Header descriptor pushes two quadlets to FIFO
// - Missed cycle jumps to skip block; zero stops
// - Header descriptor always spans 32 bytes
// - Command 1 key 0 ends the packet
// - Status bit gates result and stamp writeback
// - Interrupt control 11 raises send interrupt
// - Nonzero count sends final data fragment
// - Next descriptor from branch pointer
// - Block count fetches next block; zero ends
// - Result is run-state bits 15 to 0
// - Stamp is 3 second bits, 13 tick bits
// - Lone zero-count end sends nothing this cycle
// - Key 0 with command 0 is plain fragment
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`include "itd_map.vh"
`default_nettype none
module itd_decoder (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst_b,
    // Wishbone slave
    input  wire         wb_cyc_i,
    input  wire         wb_stb_i,
    input  wire         wb_we_i,
    input  wire [3:0]   wb_adr_i,
    input  wire [3:0]   wb_sel_i,
    input  wire [31:0]  wb_dat_i,
    output reg  [31:0]  wb_dat_o,
    output reg          wb_ack_o,
    // Descriptor fetch port
    output reg          fetchReq_ff,
    output reg  [31:0]  fetchAddr_ff,
    input  wire         fetchAck,
    input  wire [127:0] fetchData,
    // Header FIFO push
    output reg          fifoValid_ff,
    output reg  [31:0]  fifoData_ff,
    input  wire         fifoReady,
    // Payload fragment request
    output reg          fragReq_ff,
    output reg  [31:0]  fragAddr_ff,
    output reg  [15:0]  fragLen_ff,
    input  wire         fragDone,
    // Status writeback
    output reg          wbkReq_ff,
    output reg  [31:0]  wbkAddr_ff,
    output reg  [31:0]  wbkData_ff,
    input  wire         wbkAck,
    // Timer, run state and cycle events
    input  wire [6:0]   timer_second_count,
    input  wire [12:0]  timer_tick_index,
    input  wire [15:0]  channel_run_state_reg,
    input  wire         cycleStart,
    // Outputs to the controller
    output reg          iso_send_irq,
    output reg          idleCycle_ff
);

////////////////////////////////////////////////////////////////////////////////
// State codes, one-hot
localparam [6:0] ST_IDLE  = 7'h01;
localparam [6:0] ST_FETCH = 7'h02;
localparam [6:0] ST_HDR0  = 7'h04;
localparam [6:0] ST_HDR1  = 7'h08;
localparam [6:0] ST_FRAG  = 7'h10;
localparam [6:0] ST_WBK   = 7'h20;
localparam [6:0] ST_WAIT  = 7'h40;

// Address of unit n within block
function [31:0] unitAddr;
    input [31:0] base;
    input [3:0]  idx;
    begin
        unitAddr = base + {24'h0, idx, 4'h0};
    end
endfunction

// Fold a 28-bit pointer to a byte address
function [31:0] ptrAddr;
    input [27:0] p;
    begin
        ptrAddr = {p, 4'h0};
    end
endfunction

reg [6:0]   state_ff;
reg [31:0]  blockBase_ff;
reg [3:0]   blockLen_ff;
reg [3:0]   unitIdx_ff;
reg         sawFrag_ff;
reg [127:0] desc_ff;
reg [127:0] desc2_ff;
reg [27:0]  skipPtr_ff;
reg [3:0]   skipCnt_ff;
reg         runEn_ff;
reg         missed_ff;
reg         stopped_ff;
reg [27:0]  startPtr_ff;
reg [3:0]   startCnt_ff;
reg         startPulse_ff;

wire [3:0]  dCmd   = desc_ff[`ITD_CMD_HI:`ITD_CMD_LO];
wire        dStat  = desc_ff[`ITD_STAT_BIT];
wire [1:0]  dIrq   = desc_ff[`ITD_IRQ_HI:`ITD_IRQ_LO];
wire [27:0] dBrPtr = desc_ff[95:68];
wire [3:0]  dBrCnt = desc_ff[67:64];
wire        wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;

////////////////////////////////////////////////////////////////////////////////
// Wishbone register access
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        wb_ack_o      <= 1'b0;
        wb_dat_o      <= 32'h0000_0000;
        runEn_ff      <= 1'b0;
        startPtr_ff   <= 28'h000_0000;
        startCnt_ff   <= 4'h0;
        startPulse_ff <= 1'b0;
    end else begin
        wb_ack_o      <= wbReq;
        startPulse_ff <= 1'b0;
        if (wbReq && wb_we_i) begin
            case (wb_adr_i)
                `ITD_REG_CTRL: begin
                    if (wb_sel_i[0]) begin
                        runEn_ff      <= wb_dat_i[`ITD_CTRL_RUN];
                        startPulse_ff <= wb_dat_i[`ITD_CTRL_RUN];
                    end
                end
                `ITD_REG_PTR: begin
                    if (&wb_sel_i) begin
                        startPtr_ff <= wb_dat_i[31:4];
                        startCnt_ff <= wb_dat_i[3:0];
                    end
                end
                default: ;
            endcase
        end
        if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
                `ITD_REG_CTRL:  wb_dat_o <= {30'h0, missed_ff, runEn_ff};
                `ITD_REG_PTR:   wb_dat_o <= {startPtr_ff, startCnt_ff};
                `ITD_REG_STAT:  wb_dat_o <= {16'h0, stopped_ff, 8'h0, state_ff};
                `ITD_REG_TIMER: wb_dat_o <= {blockBase_ff[31:4], blockLen_ff};
                default:        wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Missed-cycle flag: set by software strobe, cleared in the wait state
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        missed_ff <= 1'b0;
    end else if (wbReq && wb_we_i && wb_adr_i == `ITD_REG_CTRL && wb_sel_i[0]
                 && wb_dat_i[`ITD_CTRL_MISSED]) begin
        missed_ff <= 1'b1;
    end else if (state_ff == ST_WAIT && missed_ff) begin
        missed_ff <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Descriptor engine
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        state_ff     <= ST_IDLE;
        blockBase_ff <= 32'h0000_0000;
        blockLen_ff  <= 4'h0;
        unitIdx_ff   <= 4'h0;
        sawFrag_ff   <= 1'b0;
        desc_ff      <= 128'h0;
        desc2_ff     <= 128'h0;
        skipPtr_ff   <= 28'h000_0000;
        skipCnt_ff   <= 4'h0;
        stopped_ff   <= 1'b0;
        fetchReq_ff  <= 1'b0;
        fetchAddr_ff <= 32'h0000_0000;
        fifoValid_ff <= 1'b0;
        fifoData_ff  <= 32'h0000_0000;
        fragReq_ff   <= 1'b0;
        fragAddr_ff  <= 32'h0000_0000;
        fragLen_ff   <= 16'h0000;
        wbkReq_ff    <= 1'b0;
        wbkAddr_ff   <= 32'h0000_0000;
        wbkData_ff   <= 32'h0000_0000;
        iso_send_irq <= 1'b0;
        idleCycle_ff <= 1'b0;
    end else begin
        iso_send_irq <= 1'b0;
        idleCycle_ff <= 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (startPulse_ff && startCnt_ff != 4'h0) begin
                    blockBase_ff <= ptrAddr(startPtr_ff);
                    blockLen_ff  <= startCnt_ff;
                    unitIdx_ff   <= 4'h0;
                    sawFrag_ff   <= 1'b0;
                    stopped_ff   <= 1'b0;
                    fetchReq_ff  <= 1'b1;
                    fetchAddr_ff <= ptrAddr(startPtr_ff);
                    state_ff     <= ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (fetchAck) begin
                    fetchReq_ff <= 1'b0;
                    desc_ff     <= fetchData;
                    if (unitIdx_ff == 4'h0) begin
                        skipPtr_ff <= fetchData[95:68];
                        skipCnt_ff <= fetchData[67:64];
                    end
                    // Command and key decoded first
                    if (fetchData[`ITD_CMD_HI:`ITD_CMD_LO] == `ITD_CMD_MORE &&
                        fetchData[`ITD_KEY_HI:`ITD_KEY_LO] == `ITD_KEY_IMM) begin
                        fetchReq_ff  <= 1'b1;
                        fetchAddr_ff <= unitAddr(blockBase_ff, unitIdx_ff + 4'h1);
                        unitIdx_ff   <= unitIdx_ff + 4'h1;
                        state_ff     <= ST_HDR0;
                    end else if (fetchData[`ITD_CMD_HI:`ITD_CMD_LO] == `ITD_CMD_MORE) begin
                        sawFrag_ff  <= 1'b1;
                        fragReq_ff  <= 1'b1;
                        fragAddr_ff <= fetchData[63:32];
                        fragLen_ff  <= fetchData[`ITD_CNT_HI:`ITD_CNT_LO];
                        state_ff    <= ST_FRAG;
                    end else if (fetchData[`ITD_CMD_HI:`ITD_CMD_LO] == `ITD_CMD_LAST) begin
                        if (fetchData[`ITD_CNT_HI:`ITD_CNT_LO] != 16'h0000) begin
                            fragReq_ff  <= 1'b1;
                            fragAddr_ff <= fetchData[63:32];
                            fragLen_ff  <= fetchData[`ITD_CNT_HI:`ITD_CNT_LO];
                            state_ff    <= ST_FRAG;
                        end else begin
                            idleCycle_ff <= ~sawFrag_ff;
                            state_ff     <= ST_WBK;
                        end
                    end else begin
                        stopped_ff <= 1'b1;
                        state_ff   <= ST_IDLE;
                    end
                end
            end
            ST_HDR0: begin
                // Second unit holds both header quadlets
                if (fetchAck) begin
                    fetchReq_ff  <= 1'b0;
                    desc2_ff     <= fetchData;
                    fifoValid_ff <= 1'b1;
                    fifoData_ff  <= fetchData[31:0];
                end else if (fifoValid_ff && fifoReady) begin
                    fifoData_ff <= desc2_ff[63:32];
                    state_ff    <= ST_HDR1;
                end
            end
            ST_HDR1: begin
                if (fifoReady) begin
                    fifoValid_ff <= 1'b0;
                    sawFrag_ff   <= 1'b1;
                    unitIdx_ff   <= unitIdx_ff + 4'h1;
                    fetchReq_ff  <= 1'b1;
                    fetchAddr_ff <= unitAddr(blockBase_ff, unitIdx_ff + 4'h1);
                    state_ff     <= ST_FETCH;
                end
            end
            ST_FRAG: begin
                if (fragDone) begin
                    fragReq_ff <= 1'b0;
                    if (dCmd == `ITD_CMD_LAST) begin
                        state_ff <= ST_WBK;
                    end else begin
                        unitIdx_ff   <= unitIdx_ff + 4'h1;
                        fetchReq_ff  <= 1'b1;
                        fetchAddr_ff <= unitAddr(blockBase_ff, unitIdx_ff + 4'h1);
                        state_ff     <= ST_FETCH;
                    end
                end
            end
            ST_WBK: begin
                if (dStat && !wbkReq_ff) begin
                    wbkReq_ff  <= 1'b1;
                    wbkAddr_ff <= unitAddr(blockBase_ff, unitIdx_ff) + 32'h0000_000c;
                    wbkData_ff <= {channel_run_state_reg[15:0],
                                   timer_second_count[2:0], timer_tick_index};
                end else if (!dStat || wbkAck) begin
                    wbkReq_ff    <= 1'b0;
                    iso_send_irq <= (dIrq == `ITD_IRQ_ON);
                    state_ff     <= ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Branch block taken on the next cycle start; skip block at once when missed
                if (!runEn_ff) begin
                    state_ff <= ST_IDLE;
                end else if (missed_ff) begin
                    if (skipCnt_ff == 4'h0) begin
                        stopped_ff <= 1'b1;
                        state_ff   <= ST_IDLE;
                    end else begin
                        blockBase_ff <= ptrAddr(skipPtr_ff);
                        blockLen_ff  <= skipCnt_ff;
                        unitIdx_ff   <= 4'h0;
                        sawFrag_ff   <= 1'b0;
                        fetchReq_ff  <= 1'b1;
                        fetchAddr_ff <= ptrAddr(skipPtr_ff);
                        state_ff     <= ST_FETCH;
                    end
                end else if (cycleStart) begin
                    if (dBrCnt == 4'h0) begin
                        stopped_ff <= 1'b1;
                        state_ff   <= ST_IDLE;
                    end else begin
                        blockBase_ff <= ptrAddr(dBrPtr);
                        blockLen_ff  <= dBrCnt;
                        unitIdx_ff   <= 4'h0;
                        sawFrag_ff   <= 1'b0;
                        fetchReq_ff  <= 1'b1;
                        fetchAddr_ff <= ptrAddr(dBrPtr);
                        state_ff     <= ST_FETCH;
                    end
                end
            end
            default: state_ff <= ST_IDLE;
        endcase
    end
end

endmodule // itd_decoder
`default_nettype wire

// >>> itd_decoder_chk.sv
// Checker for the descriptor decoder handshakes and writeback fields.
// Assumes binding to the decoder top, one clock, active-low reset.
`default_nettype none
module itd_decoder_chk (
    // Clock, reset, bus
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // Engine handshakes
    input wire logic        fetchReq_ff,
    input wire logic [31:0] fetchAddr_ff,
    input wire logic        fetchAck,
    input wire logic        fifoValid_ff,
    input wire logic [31:0] fifoData_ff,
    input wire logic        fifoReady,
    input wire logic        fragReq_ff,
    input wire logic [15:0] fragLen_ff,
    input wire logic        fragDone,
    input wire logic        wbkReq_ff,
    input wire logic [31:0] wbkAddr_ff,
    input wire logic [31:0] wbkData_ff,
    input wire logic        wbkAck,
    // Sampled inputs, events
    input wire logic [6:0]  timer_second_count,
    input wire logic [12:0] timer_tick_index,
    input wire logic [15:0] channel_run_state_reg,
    input wire logic        iso_send_irq,
    input wire logic        idleCycle_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////
    a_bus_ack_once: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse one cycle after request");
    a_fetch_aligned: assert property (
        fetchReq_ff |-> fetchAddr_ff[3:0] == 4'h0)
        else $error("fetch address not unit aligned");
    a_fetch_held: assert property (
        fetchReq_ff && !fetchAck |=> fetchReq_ff && $stable(fetchAddr_ff))
        else $error("fetch request dropped or moved before ack");
    a_push_held: assert property (
        fifoValid_ff && !fifoReady |=> fifoValid_ff && $stable(fifoData_ff))
        else $error("header push changed while stalled");
    a_frag_nonzero: assert property (
        fragReq_ff |-> fragLen_ff != 16'h0000)
        else $error("fragment requested with zero length");
    a_frag_held: assert property (
        fragReq_ff && !fragDone |=> fragReq_ff && $stable(fragLen_ff))
        else $error("fragment request not held until done");
    a_stamp_fields: assert property (
        wbkReq_ff |-> wbkData_ff ==
        {channel_run_state_reg, timer_second_count[2:0], timer_tick_index})
        else $error("writeback result or stamp wrong");
    a_wbk_slot: assert property (
        wbkReq_ff && !wbkAck |=> wbkReq_ff && $stable(wbkAddr_ff) && wbkAddr_ff[3:0] == 4'hc)
        else $error("writeback slot wrong or not held");
    a_irq_pulse: assert property (
        iso_send_irq |=> !iso_send_irq)
        else $error("send interrupt longer than one cycle");
    a_idle_quiet: assert property (
        idleCycle_ff |-> !fragReq_ff && !fifoValid_ff)
        else $error("traffic during idle cycle");
    // Main scenarios seen
    c_push: cover property (fifoValid_ff && fifoReady);
    c_frag: cover property (fragReq_ff && fragDone);
    c_wbk: cover property (wbkReq_ff && wbkAck);
    c_idle: cover property (idleCycle_ff);
endmodule // itd_decoder_chk
bind itd_decoder itd_decoder_chk itd_decoder_chk_inst (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .fetchReq_ff, .fetchAddr_ff, .fetchAck, .fifoValid_ff, .fifoData_ff, .fifoReady,
    .fragReq_ff, .fragLen_ff, .fragDone, .wbkReq_ff, .wbkAddr_ff, .wbkData_ff, .wbkAck,
    .timer_second_count, .timer_tick_index, .channel_run_state_reg, .iso_send_irq,
    .idleCycle_ff);
`default_nettype wire

// >>> itd_host_mem.sv
// Host memory model: descriptor units, payload mover, writeback, FIFO.
// Assumes the bench loads mem before the context is started.
`default_nettype none
module itd_host_mem (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    // Descriptor fetch
    input  wire logic         fetchReq_ff,
    input  wire logic [31:0]  fetchAddr_ff,
    output var  logic         fetchAck,
    output var  logic [127:0] fetchData,
    // Payload, writeback, FIFO
    input  wire logic         fragReq_ff,
    output var  logic         fragDone,
    input  wire logic         wbkReq_ff,
    output var  logic         wbkAck,
    output var  logic         fifoReady
);
    logic [127:0] mem [0:255];
    logic [1:0]   waitCnt;
    logic         slow;
    // Fetch answers alternate prompt and slow; data scrambled outside acks
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fetchAck <= 1'b0;
            fetchData <= '0;
            waitCnt <= 2'd0;
            slow <= 1'b0;
            fragDone <= 1'b0;
            wbkAck <= 1'b0;
            fifoReady <= 1'b0;
        end else begin
            fetchAck <= 1'b0;
            fetchData <= ~fetchData;
            fragDone <= fragReq_ff && !fragDone;
            wbkAck <= wbkReq_ff && !wbkAck;
            fifoReady <= ~fifoReady;
            if (fetchReq_ff && !fetchAck) begin
                waitCnt <= waitCnt + 2'd1;
                if (waitCnt == {slow, slow}) begin
                    fetchAck <= 1'b1;
                    fetchData <= mem[fetchAddr_ff[11:4]];
                    waitCnt <= 2'd0;
                    slow <= ~slow;
                end
            end
        end
    end
endmodule // itd_host_mem
`default_nettype wire

// >>> test_itd_decoder.sv
// Bench for the descriptor decoder: header block, missed cycle, idle blocks.
// Assumes the decoder register map header and a 100 MHz clock.
`include "itd_map.vh"
`default_nettype none
module test_itd_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] QUAD0 = 32'h1357_9bdf;
    localparam logic [31:0] QUAD1 = 32'h2468_ace0;
    logic         clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cycleStart;
    logic [3:0]   wb_adr_i, wb_sel_i;
    logic [31:0]  wb_dat_i, wb_dat_o, fetchAddr_ff, fifoData_ff, fragAddr_ff, rd;
    logic [31:0]  wbkAddr_ff, wbkData_ff;
    logic         fetchReq_ff, fetchAck, fifoValid_ff, fifoReady, fragReq_ff, fragDone;
    logic         wbkReq_ff, wbkAck, iso_send_irq, idleCycle_ff;
    logic [127:0] fetchData;
    logic [15:0]  fragLen_ff, channel_run_state_reg;
    logic [6:0]   timer_second_count;
    logic [12:0]  timer_tick_index;
    logic [31:0]  fetchQ [$];
    logic [31:0]  pushQ [$];
    logic [63:0]  fragQ [$];
    logic [63:0]  wbkQ [$];
    logic [31:0]  expFetch [5] = '{32'h100, 32'h110, 32'h120, 32'h400, 32'h200};
    int           irqN, idleN, mismatches, tests_run;
    itd_decoder itd_decoder_inst (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fetchReq_ff, .fetchAddr_ff, .fetchAck,
        .fetchData, .fifoValid_ff, .fifoData_ff, .fifoReady, .fragReq_ff, .fragAddr_ff,
        .fragLen_ff, .fragDone, .wbkReq_ff, .wbkAddr_ff, .wbkData_ff, .wbkAck,
        .timer_second_count, .timer_tick_index, .channel_run_state_reg, .cycleStart,
        .iso_send_irq, .idleCycle_ff);
    itd_host_mem itd_host_mem_inst (.clk_sys, .rst_b, .fetchReq_ff, .fetchAddr_ff, .fetchAck,
        .fetchData, .fragReq_ff, .fragDone, .wbkReq_ff, .wbkAck, .fifoReady);
    ////////////////////////////////////////////////////////////////////////////
    // Records engine traffic at each edge
    always @(posedge clk_sys) begin
        if (fetchReq_ff && fetchAck) fetchQ.push_back(fetchAddr_ff);
        if (fifoValid_ff && fifoReady) pushQ.push_back(fifoData_ff);
        if (fragReq_ff && fragDone) fragQ.push_back({16'h0, fragLen_ff, fragAddr_ff});
        if (wbkReq_ff && wbkAck) wbkQ.push_back({wbkAddr_ff, wbkData_ff});
        irqN += int'(iso_send_irq === 1'b1);
        idleN += int'(idleCycle_ff === 1'b1);
    end
    function automatic logic [127:0] unit(logic [31:0] q, b, p, logic [3:0] z);
        return {32'h0, p[31:4], z, b, q};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic bus cycle, held until ack is sampled
    task automatic wb_rw(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // Unbounded: ends on ack, or by the watchdog if no ack comes
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Cycle start pulse, then bounded wait for event counts
    task automatic next_cycle(input int irqW, input int idleW);
        int n;
        @(posedge clk_sys);
        cycleStart <= 1'b1;
        @(posedge clk_sys);
        cycleStart <= 1'b0;
        n = 0;
        while ((irqN < irqW || idleN < idleW) && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (20) @(posedge clk_sys);
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        report_and_stop;
    end
    // Main sequence
    initial begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, cycleStart} = 5'h0;
        {wb_adr_i, wb_dat_i, wb_sel_i} = {4'h0, 32'h0, 4'hf};
        {timer_second_count, timer_tick_index} = {7'h5d, 13'h1abc};
        channel_run_state_reg = 16'h8421;
        itd_host_mem_inst.mem[8'h10] = unit(32'h0200_0008, 32'h0, 32'h400, 4'h1);
        itd_host_mem_inst.mem[8'h11] = {64'h0, QUAD1, QUAD0};
        itd_host_mem_inst.mem[8'h12] = unit(32'h183c_0040, 32'h1234_5678, 32'h200, 4'h1);
        itd_host_mem_inst.mem[8'h40] = unit(32'h183c_0000, 32'h0, 32'h200, 4'h1);
        itd_host_mem_inst.mem[8'h20] = unit(32'h100c_0000, 32'h0, 32'h0, 4'h0);
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        wb_rw(1'b1, `ITD_REG_PTR, 32'h0000_0103);
        wb_rw(1'b0, `ITD_REG_PTR, 32'h0);
        chk({32'h0, rd}, 64'h0000_0103);
        wb_rw(1'b0, 4'h2, 32'h0);
        chk({32'h0, rd}, 64'h0);
        wb_rw(1'b1, `ITD_REG_CTRL, 32'h1);
        next_cycle(1, 0);
        // Run bit kept set while the missed cycle is flagged
        wb_rw(1'b1, `ITD_REG_CTRL, 32'h3);
        timer_tick_index <= 13'h0f0f;
        next_cycle(2, 1);
        next_cycle(2, 2);
        next_cycle(2, 2);
        wb_rw(1'b0, `ITD_REG_STAT, 32'h0);
        chk({63'h0, rd[15]}, 64'h1);
        wb_rw(1'b0, `ITD_REG_TIMER, 32'h0);
        chk({32'h0, rd}, 64'h0000_0201);
        for (int k = 0; k < 5; k++) chk({32'h0, fetchQ[k]}, {32'h0, expFetch[k]});
        chk(64'(fetchQ.size()), 64'd5);
        chk({pushQ[0], pushQ[1]}, {QUAD0, QUAD1});
        chk(64'(pushQ.size()), 64'd2);
        chk(fragQ[0], 64'h0000_0040_1234_5678);
        chk(64'(fragQ.size()), 64'd1);
        chk(wbkQ[0], {32'h0000_012c, 16'h8421, 3'h5, 13'h1abc});
        chk(wbkQ[1], {32'h0000_040c, 16'h8421, 3'h5, 13'h0f0f});
        chk(64'(wbkQ.size()), 64'd2);
        chk(64'(irqN), 64'd2);
        chk(64'(idleN), 64'd2);
        report_and_stop;
    end
endmodule // test_itd_decoder
`default_nettype wire
